/* File: acs_ana_model.sv */
`timescale 1ns/1ns
module acs_ana_model
  import acs_pkg::*;
(
  input wire logic clk,
  input wire logic [3:0] mux_sel,
  input wire logic sample_en,
  input wire logic [RES_W-1:0] dac_trial,
  output logic cmp_out
);
  logic [RES_W-1:0] held_r = '0;
  // Each channel carries its own fixed level.
  function automatic logic [RES_W-1:0] level(input logic [3:0] ch);
    return 10'h02A + 10'h025 * ch;
  endfunction
  // The hold capacitor follows the selected channel only while sampling.
  always @(posedge clk) begin
    if (sample_en) begin
      held_r <= level(mux_sel);
    end
  end
  assign cmp_out = held_r >= dac_trial;
endmodule // acs_ana_model

/* File: acs_pkg.sv */
package acs_pkg;
  localparam int unsigned NCH = 16;
  localparam int unsigned RES_W = 10;
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_RESULT = 12'h004;
  localparam logic [11:0] OFF_INJ = 12'h008;
  localparam logic [11:0] OFF_STAT = 12'h00C;
  localparam logic [11:0] OFF_MASK = 12'h010;
  localparam logic [11:0] OFF_DIN = 12'h014;
  localparam logic [11:0] OFF_MSEL = 12'h018;
  // Control register fields.
  localparam int unsigned C_CH = 0;
  localparam int unsigned C_MODE = 4;
  localparam int unsigned C_START = 7;
  localparam int unsigned C_WR = 9;
  localparam int unsigned C_SUSP = 10;
  localparam int unsigned C_CTC = 12;
  localparam int unsigned C_STC = 14;
  localparam int unsigned C_INJ = 16;
  localparam int unsigned C_INJCH = 20;
  localparam int unsigned C_BUSY = 8;
  // Status bits.
  localparam int unsigned S_DONE = 0;
  localparam int unsigned S_OVR = 1;
  localparam int unsigned S_INJ = 2;
  localparam int unsigned S_W = 3;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] MSEL_RST = 32'h0000_0001;
  // Mode bit 0 is continuous, bit 1 is scan.
  localparam int unsigned M_CONT = 0;
  localparam int unsigned M_SCAN = 1;
  localparam logic [6:0] CTC_24 = 7'd24;
  localparam logic [6:0] CTC_96 = 7'd96;
  localparam logic [6:0] CTC_48 = 7'd48;
  localparam logic [3:0] CONV_STEPS = 4'd10;
  typedef enum logic [2:0] {ST_IDLE, ST_SAMPLE, ST_CONV, ST_HOLD, ST_NEXT} acs_state_e;
endpackage

/* File: acs_tick_div.sv */
`timescale 1ns/1ns
module acs_tick_div
  import acs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [1:0] ctc,
  output logic tcl_tick,
  output logic cc_tick
);
  logic half_r;
  logic half_nxt;
  logic [6:0] cnt_r;
  logic [6:0] cnt_nxt;
  logic [6:0] div;

  always_comb begin
    unique case (ctc)
      2'b10: div = CTC_96;
      2'b11: div = CTC_48;
      default: div = CTC_24;
    endcase
    // The tick phase restarts with each run so that sample and conversion windows are exact.
    half_nxt = run ? ~half_r : 1'b0;
    tcl_tick = half_r;
    cnt_nxt = cnt_r;
    cc_tick = 1'b0;
    if (!run) begin
      cnt_nxt = '0;
    end else if (tcl_tick) begin
      if (cnt_r >= div - 7'd1) begin
        cnt_nxt = '0;
        cc_tick = 1'b1;
      end else begin
        cnt_nxt = cnt_r + 7'd1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      half_r <= 1'b0;
      cnt_r <= '0;
    end else begin
      half_r <= half_nxt;
      cnt_r <= cnt_nxt;
    end
  end
endmodule // acs_tick_div

/* File: acs_top.sv */
`timescale 1ns/1ns
module acs_top
  import acs_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic [3:0] MUX_SEL,
  output logic SAMPLE_EN,
  output logic [RES_W-1:0] DAC_TRIAL,
  input wire logic CMP_IN,
  input wire logic [NCH-1:0] AIN_DIG,
  output logic XFER_REQ,
  output logic IRQ
);
  logic [31:0] ctrl_r, ctrl_nxt;
  logic [15:0] msel_r, msel_nxt;
  logic [3:0] stat_r, stat_nxt;
  logic [3:0] mask_r, mask_nxt;
  logic [RES_W+3:0] res_r, res_nxt;
  logic [RES_W+3:0] buf_r, buf_nxt;
  logic buf_v_r, buf_v_nxt;
  logic unread_r, unread_nxt;
  logic [RES_W+3:0] inj_r, inj_nxt;
  logic inj_act_r, inj_act_nxt;
  acs_state_e st_r, st_nxt;
  logic [3:0] ch_r, ch_nxt;
  logic [3:0] cur_r, cur_nxt;
  logic [3:0] step_r, step_nxt;
  logic [RES_W-1:0] sar_r, sar_nxt;
  logic [3:0] scnt_r, scnt_nxt;
  logic xfer_r, xfer_nxt;
  logic [NCH-1:0] din_s1_r, din_s2_r;
  logic cmp_s1_r, cmp_s2_r;
  logic wr, rd, tcl_tick, cc_tick, run;
  logic [3:0] samp_len;
  logic cont, scan, done_conv;
  logic [3:0] nxt_sc;
  logic found;

  acs_tick_div u_div (
    .clk(CLK_SYS),
    .rst_n(RSTN),
    .run(run),
    .ctc(ctrl_r[C_CTC+:2]),
    .tcl_tick(tcl_tick),
    .cc_tick(cc_tick)
  );

  assign wr = PSEL && PENABLE && PWRITE;
  assign rd = PSEL && PENABLE && !PWRITE;
  assign PREADY = 1'b1;
  assign run = (st_r == ST_SAMPLE) || (st_r == ST_CONV);
  assign cont = ctrl_r[C_MODE+M_CONT];
  assign scan = ctrl_r[C_MODE+M_SCAN];
  assign MUX_SEL = cur_r;
  assign SAMPLE_EN = (st_r == ST_SAMPLE);
  assign DAC_TRIAL = sar_r | (RES_W'(1) << (RES_W - 1 - step_r));
  assign XFER_REQ = xfer_r;
  assign IRQ = |(stat_r & mask_r);

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      din_s1_r <= '0;
      din_s2_r <= '0;
      cmp_s1_r <= 1'b0;
      cmp_s2_r <= 1'b0;
    end else begin
      din_s1_r <= AIN_DIG;
      din_s2_r <= din_s1_r;
      cmp_s1_r <= CMP_IN;
      cmp_s2_r <= cmp_s1_r;
    end
  end

  always_comb begin
    unique case (ctrl_r[C_STC+:2])
      2'b00: samp_len = 4'd1;
      2'b01: samp_len = 4'd2;
      2'b10: samp_len = 4'd4;
      default: samp_len = 4'd8;
    endcase
    // Next selected scan channel, counting downward and wrapping.
    nxt_sc = ch_r;
    found = 1'b0;
    for (int i = 1; i <= NCH; i++) begin
      if (!found && msel_r[4'(ch_r - 4'(i))]) begin
        nxt_sc = 4'(ch_r - 4'(i));
        found = 1'b1;
      end
    end
  end

  always_comb begin
    ctrl_nxt = ctrl_r;
    msel_nxt = msel_r;
    stat_nxt = stat_r;
    mask_nxt = mask_r;
    res_nxt = res_r;
    buf_nxt = buf_r;
    buf_v_nxt = buf_v_r;
    unread_nxt = unread_r;
    inj_nxt = inj_r;
    inj_act_nxt = inj_act_r;
    st_nxt = st_r;
    ch_nxt = ch_r;
    cur_nxt = cur_r;
    step_nxt = step_r;
    sar_nxt = sar_r;
    scnt_nxt = scnt_r;
    xfer_nxt = 1'b0;
    done_conv = 1'b0;
    PRDATA = 32'h0000_0000;
    PSLVERR = 1'b0;
    if (rd) begin
      unique case (PADDR)
        OFF_CTRL: PRDATA = ctrl_r | (32'(run || st_r == ST_HOLD || st_r == ST_NEXT) << C_BUSY);
        OFF_RESULT: PRDATA = {18'h0_0000, res_r};
        OFF_INJ: PRDATA = {18'h0_0000, inj_r};
        OFF_STAT: PRDATA = {28'h000_0000, stat_r};
        OFF_MASK: PRDATA = {28'h000_0000, mask_r};
        OFF_DIN: PRDATA = {16'h0000, din_s2_r};
        OFF_MSEL: PRDATA = {16'h0000, msel_r};
        default: PSLVERR = 1'b1;
      endcase
      if (PADDR == OFF_RESULT) begin
        unread_nxt = 1'b0;
      end
    end
    if (wr) begin
      unique case (PADDR)
        OFF_CTRL: ctrl_nxt = PWDATA;
        OFF_STAT: stat_nxt = stat_r & ~PWDATA[3:0];
        OFF_MASK: mask_nxt = PWDATA[3:0];
        OFF_MSEL: msel_nxt = PWDATA[15:0];
        OFF_RESULT, OFF_INJ, OFF_DIN: ;
        default: PSLVERR = 1'b1;
      endcase
    end
    // Buffered result moves up once the result register has been read.
    if (buf_v_r && !unread_nxt) begin
      res_nxt = buf_r;
      buf_v_nxt = 1'b0;
      unread_nxt = 1'b1;
    end
    unique case (st_r)
      ST_IDLE: begin
        if (ctrl_r[C_START]) begin
          ctrl_nxt[C_START] = 1'b0;
          ch_nxt = ctrl_r[C_CH+:4];
          cur_nxt = ctrl_r[C_CH+:4];
          st_nxt = ST_SAMPLE;
          scnt_nxt = '0;
        end
      end
      ST_SAMPLE: begin
        if (cc_tick) begin
          if (scnt_r == samp_len - 4'd1) begin
            st_nxt = ST_CONV;
            step_nxt = '0;
            sar_nxt = '0;
          end else begin
            scnt_nxt = scnt_r + 4'd1;
          end
        end
      end
      ST_CONV: begin
        if (cc_tick) begin
          if (cmp_s2_r) begin
            sar_nxt = DAC_TRIAL;
          end
          if (step_r == CONV_STEPS - 4'd1) begin
            done_conv = 1'b1;
          end else begin
            step_nxt = step_r + 4'd1;
          end
        end
      end
      ST_HOLD: begin
        // A buffered result leaves the hold when it moves up, since the move marks it unread again.
        if (buf_v_r ? !buf_v_nxt : !unread_r) begin
          st_nxt = ST_NEXT;
        end
      end
      ST_NEXT: ;
      default: st_nxt = ST_IDLE;
    endcase
    if (done_conv) begin
      st_nxt = ST_NEXT;
      if (inj_act_r) begin
        inj_nxt = {cur_r, (cmp_s2_r ? DAC_TRIAL : sar_r)};
        inj_act_nxt = 1'b0;
        stat_nxt[S_INJ] = 1'b1;
      end else begin
        if (scan) begin
          xfer_nxt = 1'b1;
        end
        stat_nxt[S_DONE] = 1'b1;
        if (unread_nxt && cont && ctrl_r[C_WR]) begin
          buf_nxt = {cur_r, (cmp_s2_r ? DAC_TRIAL : sar_r)};
          buf_v_nxt = 1'b1;
          stat_nxt[S_W] = 1'b1;
          st_nxt = ST_HOLD;
        end else begin
          if (unread_nxt) begin
            stat_nxt[S_OVR] = 1'b1;
          end
          res_nxt = {cur_r, (cmp_s2_r ? DAC_TRIAL : sar_r)};
          unread_nxt = 1'b1;
          if (ctrl_r[C_SUSP]) begin
            st_nxt = ST_HOLD;
          end
        end
      end
    end
    if (st_r == ST_NEXT) begin
      scnt_nxt = '0;
      if (cont && ctrl_r[C_INJ] && !inj_act_r) begin
        ctrl_nxt[C_INJ] = 1'b0;
        inj_act_nxt = 1'b1;
        cur_nxt = ctrl_r[C_INJCH+:4];
        st_nxt = ST_SAMPLE;
      end else if (scan && ch_r != 4'd0) begin
        ch_nxt = nxt_sc;
        cur_nxt = nxt_sc;
        st_nxt = ST_SAMPLE;
      end else if (cont) begin
        ch_nxt = ctrl_r[C_CH+:4];
        cur_nxt = ctrl_r[C_CH+:4];
        st_nxt = ST_SAMPLE;
      end else begin
        st_nxt = ST_IDLE;
      end
      if (scan && ch_r != 4'd0 && !found) begin
        st_nxt = cont ? ST_SAMPLE : ST_IDLE;
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      ctrl_r <= CTRL_RST;
      msel_r <= MSEL_RST[15:0];
      stat_r <= '0;
      mask_r <= '0;
      res_r <= '0;
      buf_r <= '0;
      buf_v_r <= 1'b0;
      unread_r <= 1'b0;
      inj_r <= '0;
      inj_act_r <= 1'b0;
      st_r <= ST_IDLE;
      ch_r <= '0;
      cur_r <= '0;
      step_r <= '0;
      sar_r <= '0;
      scnt_r <= '0;
      xfer_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      msel_r <= msel_nxt;
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      res_r <= res_nxt;
      buf_r <= buf_nxt;
      buf_v_r <= buf_v_nxt;
      unread_r <= unread_nxt;
      inj_r <= inj_nxt;
      inj_act_r <= inj_act_nxt;
      st_r <= st_nxt;
      ch_r <= ch_nxt;
      cur_r <= cur_nxt;
      step_r <= step_nxt;
      sar_r <= sar_nxt;
      scnt_r <= scnt_nxt;
      xfer_r <= xfer_nxt;
    end
  end
endmodule // acs_top

/* File: acs_top_sva.sv */
`timescale 1ns/1ns
module acs_top_sva
  import acs_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic [3:0] MUX_SEL,
  input wire logic SAMPLE_EN,
  input wire logic [NCH-1:0] AIN_DIG,
  input wire logic XFER_REQ,
  input wire logic IRQ
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);
  sequence din_read_s;
    PSEL && PENABLE && !PWRITE && PADDR == OFF_DIN;
  endsequence
  pready_high_a: assert property (PREADY)
    else $error("pready low");
  slverr_access_a: assert property (PSLVERR |-> PSEL && PENABLE)
    else $error("pslverr outside access");
  rdata_idle_a: assert property (!(PSEL && PENABLE) |-> PRDATA == 32'h0000_0000)
    else $error("prdata not zero when idle");
  din_pins_a: assert property (din_read_s |-> PRDATA[NCH-1:0] == $past(AIN_DIG, 2))
    else $error("pin read mismatch");
  sample_min_a: assert property ($rose(SAMPLE_EN) |-> SAMPLE_EN [*8])
    else $error("sample too short");
  conv_after_a: assert property ($fell(SAMPLE_EN) |-> !SAMPLE_EN [*8])
    else $error("no conversion after sample");
  mux_stable_a: assert property (SAMPLE_EN && $past(SAMPLE_EN) |-> $stable(MUX_SEL))
    else $error("channel moved while sampling");
  xfer_pulse_a: assert property (XFER_REQ |-> !SAMPLE_EN ##1 !XFER_REQ)
    else $error("transfer request not one pulse");
  reset_quiet_a: assert property ($rose(RSTN) |-> !IRQ && !XFER_REQ && !SAMPLE_EN)
    else $error("outputs active after reset");
endmodule // acs_top_sva
bind acs_top acs_top_sva acs_top_sva_inst (.CLK_SYS(CLK_SYS), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .MUX_SEL(MUX_SEL),
  .SAMPLE_EN(SAMPLE_EN), .AIN_DIG(AIN_DIG), .XFER_REQ(XFER_REQ), .IRQ(IRQ));

/* File: acs_top_tb.sv */
`timescale 1ns/1ns
module acs_top_tb
  import acs_pkg::*;
;
  localparam logic [31:0] cont_b = 32'h1 << (C_MODE + M_CONT);
  localparam logic [31:0] start_b = 32'h1 << C_START;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, prev_se = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [NCH-1:0] ain = 16'hA5C3;
  logic [31:0] prdata, q;
  logic pready, pslverr, se, cmp, xfer, irq, err;
  logic [3:0] msel;
  logic [RES_W-1:0] dac;
  logic [1:0] ctc [4] = '{2'h0, 2'h2, 2'h3, 2'h0};
  int tcc [4] = '{2 * CTC_24, 2 * CTC_96, 2 * CTC_48, 2 * CTC_24};
  int bad_count = 0, checked = 0, run_len = 0, last_len = 0, rises = 0, xfers = 0, snap;
  always #2 clk = ~clk;
  acs_top acs_top_inst (.CLK_SYS(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .MUX_SEL(msel),
    .SAMPLE_EN(se), .DAC_TRIAL(dac), .CMP_IN(cmp), .AIN_DIG(ain), .XFER_REQ(xfer), .IRQ(irq));
  acs_ana_model acs_ana_model_inst (.clk(clk), .mux_sel(msel), .sample_en(se), .dac_trial(dac), .cmp_out(cmp));
  function automatic logic [31:0] res(input logic [3:0] ch);
    return {18'h0_0000, ch, 10'h02A + 10'h025 * ch};
  endfunction
  // Measures sample windows and counts sample starts and transfer pulses.
  always @(posedge clk) begin
    if (se === 1'b1) run_len <= run_len + 1;
    else if (run_len != 0) begin
      last_len <= run_len;
      run_len <= 0;
    end
    if (se === 1'b1 && !prev_se) rises <= rises + 1;
    prev_se <= (se === 1'b1);
    if (xfer === 1'b1) xfers <= xfers + 1;
  end
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 3000; i++) begin
      apb(1'b0, OFF_CTRL, 32'h0000_0000);
      if (i == 0) chk("busy", 32'h1, {31'h0, q[C_BUSY]});
      if (q[C_BUSY] === 1'b0) break;
    end
    chk("idle", 32'h0, {31'h0, q[C_BUSY]});
  endtask
  task automatic wait_irq(input int n);
    repeat (n) if (irq !== 1'b1) @(posedge clk);
    chk("irq", 32'h1, {31'h0, irq});
  endtask
  task automatic do_reset();
    rstn <= 1'b0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
  endtask
  task automatic print_verdict();
    $display("checked %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    do_reset();
    apb(1'b0, OFF_CTRL, 32'h0); chk("ctrl_rst", CTRL_RST, q);
    apb(1'b0, OFF_MSEL, 32'h0); chk("msel_rst", MSEL_RST, q);
    apb(1'b0, OFF_DIN, 32'h0); chk("din", 32'h0000_A5C3, q);
    apb(1'b0, 12'h0FC, 32'h0); chk("slverr", 32'h1, {31'h0, err});
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, OFF_CTRL, 32'h3 | (32'(ctc[k]) << C_CTC) | (32'(k) << C_STC) | start_b);
      wait_idle();
      chk("sample_len", tcc[k] << k, 32'(last_len));
      apb(1'b0, OFF_RESULT, 32'h0); chk("result", res(4'h3), q);
    end
    apb(1'b1, OFF_MSEL, 32'h0000_0007);
    apb(1'b1, OFF_MASK, 32'h1 << S_DONE);
    snap = xfers;
    apb(1'b1, OFF_CTRL, 32'h2 | (32'h1 << (C_MODE + M_SCAN)) | start_b);
    wait_idle();
    chk("xfers", 32'h3, 32'(xfers - snap));
    apb(1'b0, OFF_RESULT, 32'h0); chk("scan_last", res(4'h0), q);
    @(negedge clk); chk("irq_on", 32'h1, {31'h0, irq});
    apb(1'b1, OFF_MASK, 32'h0);
    @(negedge clk); chk("irq_masked", 32'h0, {31'h0, irq});
    apb(1'b1, OFF_STAT, 32'h0000_000F);
    apb(1'b0, OFF_STAT, 32'h0); chk("stat_clr", 32'h0, q);
    do_reset();
    apb(1'b1, OFF_MASK, 32'h1 << S_W);
    apb(1'b1, OFF_CTRL, 32'h5 | cont_b | (32'h1 << C_WR) | start_b);
    wait_irq(4000);
    snap = rises;
    repeat (1200) @(posedge clk);
    chk("held", 32'h0, 32'(rises - snap));
    apb(1'b0, OFF_RESULT, 32'h0); chk("cont_res", res(4'h5), q);
    apb(1'b1, OFF_MASK, 32'h1 << S_INJ);
    apb(1'b1, OFF_CTRL, 32'h5 | cont_b | (32'h1 << C_INJ) | (32'h9 << C_INJCH));
    wait_irq(4000);
    apb(1'b0, OFF_INJ, 32'h0); chk("inj_res", res(4'h9), q);
    apb(1'b0, OFF_CTRL, 32'h0); chk("mode_kept", 32'h1, 32'(q[C_MODE +: 2]));
    do_reset();
    apb(1'b1, OFF_MSEL, 32'h0000_0003);
    apb(1'b1, OFF_MASK, 32'h1 << S_OVR);
    apb(1'b1, OFF_CTRL, 32'h1 | (32'h3 << C_MODE) | start_b);
    wait_irq(4000);
    snap = xfers;
    repeat (1500) @(posedge clk);
    chk("scan_repeat", 32'h1, 32'(xfers - snap >= 2));
    print_verdict();
  end
  initial begin
    repeat (60000) @(posedge clk);
    bad_count++;
    print_verdict();
  end
endmodule // acs_top_tb
